//--- src/two_wire_config_slave.sv
// two-wire configuration slave: framing, addressing, register file, nv control
// assumes scl and sda pins are asynchronous and pulled up outside; scl is
// only an input since the slave never stretches the clock
`timescale 1ns/1ps
module two_wire_config_slave #(
    parameter int NV_WRITE_TIME_US = 10000
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // two-wire bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // configuration outputs
    output logic [7:0]      prescaler_cfg,
    output logic [3:0]      freq_cfg,
    output logic [2:0]      bus_id,
    output logic            nv_write_defer,
    // nonvolatile store control
    output logic            nv_store,
    output logic            nv_busy
);

    localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * cfg_slave_pkg::CLK_FREQ_MHZ;

    // synchronised pins and their delayed copies
    logic [1:0] pins_sync;
    logic       scl_prev;
    logic       sda_prev;

    // protocol state
    cfg_slave_pkg::state_t state;
    cfg_slave_pkg::state_t next_state;
    logic [3:0]            bit_cnt;
    logic [3:0]            next_bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            next_shift;
    logic                  rw;
    logic [7:0]            mem_addr;
    logic                  master_ack;
    logic                  next_drive;
    logic                  pending;

    // pin synchronisers: scl on bit 1, sda on bit 0
    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pin_in   ({scl_in, sda_in}),
        .pin_sync (pins_sync)
    );

    wire scl_s = pins_sync[1];
    wire sda_s = pins_sync[0];

    // delayed copies for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    // bus events
    wire scl_rise   = scl_s & ~scl_prev;
    wire scl_fall   = ~scl_s & scl_prev;
    wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;
    // data only moves on clock edges, so sda edges with scl high are framing
    wire sample_bit = scl_rise & (bit_cnt < cfg_slave_pkg::CNT_DATA);

    // clock edge phases of a byte
    wire ack_fall  = scl_fall & (bit_cnt == cfg_slave_pkg::CNT_DATA);
    wire end_fall  = scl_fall & (bit_cnt == cfg_slave_pkg::CNT_ACK);
    wire data_fall = scl_fall & (bit_cnt != cfg_slave_pkg::CNT_ZERO)
                   & (bit_cnt < cfg_slave_pkg::CNT_DATA);
    wire ack_rise  = scl_rise & (bit_cnt == cfg_slave_pkg::CNT_DATA);

    // state decodes
    wire in_dev  = (state == cfg_slave_pkg::ST_DEV_ADDR);
    wire in_mem  = (state == cfg_slave_pkg::ST_MEM_ADDR);
    wire in_wr   = (state == cfg_slave_pkg::ST_WR_DATA);
    wire in_rd   = (state == cfg_slave_pkg::ST_RD_DATA);
    wire active  = in_dev | in_mem | in_wr | in_rd;
    wire receive = in_dev | in_mem | in_wr;

    // slave address compare: fixed upper bits, bus id below, busy refuses
    wire [6:0] own_addr   = {cfg_slave_pkg::SLAVE_ADDR_HI, bus_id};
    wire       addr_hit   = (shift[7:1] == own_addr);
    wire       addr_match = addr_hit & ~nv_busy;
    wire       dir_read   = shift[0];

    // acknowledge decision at the end of a received byte
    wire ack_now = in_dev ? addr_match : (in_mem | in_wr);

    // a new read byte starts after an address ack or a master ack
    wire start_read = (in_dev & rw) | (in_rd & master_ack);

    // register write decodes, taken at the end of a data byte
    wire write_byte = ack_fall & in_wr;
    wire hit_pre    = (mem_addr == cfg_slave_pkg::REG_PRESCALER);
    wire hit_freq   = (mem_addr == cfg_slave_pkg::REG_FREQ);
    wire hit_id     = (mem_addr == cfg_slave_pkg::REG_BUS_ID);
    wire wr_pre     = write_byte & hit_pre;
    wire wr_freq    = write_byte & hit_freq;
    wire wr_id      = write_byte & hit_id;

    // commit command is the register address byte itself, with no data
    wire commit_cmd = ack_fall & in_mem & (shift == cfg_slave_pkg::CMD_NV_COMMIT);

    // a write needs nonvolatile storage unless deferred; bus id always does
    wire nv_needed = ((wr_pre | wr_freq) & ~nv_write_defer)
                   | wr_id
                   | commit_cmd;

    // read data selection, unused upper bits read as one
    wire [7:0] reg_bus_id = {cfg_slave_pkg::UPPER_FILL, nv_write_defer, bus_id};
    wire [7:0] reg_freq   = {cfg_slave_pkg::UPPER_FILL, freq_cfg};
    wire [7:0] read_byte  = hit_pre  ? prescaler_cfg :
                            hit_freq ? reg_freq      :
                            hit_id   ? reg_bus_id    :
                            cfg_slave_pkg::UNMAPPED_READ;

    // next state of the transfer
    always_comb begin
        next_state = state;
        if (start_cond) begin
            next_state = cfg_slave_pkg::ST_DEV_ADDR;
        end else if (stop_cond) begin
            next_state = cfg_slave_pkg::ST_IDLE;
        end else begin
            case (state)
                cfg_slave_pkg::ST_DEV_ADDR: begin
                    if (ack_fall & ~addr_match) begin
                        next_state = cfg_slave_pkg::ST_IGNORE;
                    end else if (end_fall) begin
                        next_state = rw ? cfg_slave_pkg::ST_RD_DATA
                                        : cfg_slave_pkg::ST_MEM_ADDR;
                    end
                end
                cfg_slave_pkg::ST_MEM_ADDR: begin
                    if (end_fall) begin
                        next_state = cfg_slave_pkg::ST_WR_DATA;
                    end
                end
                cfg_slave_pkg::ST_RD_DATA: begin
                    if (end_fall & ~master_ack) begin
                        next_state = cfg_slave_pkg::ST_IGNORE;
                    end
                end
                cfg_slave_pkg::ST_WR_DATA,
                cfg_slave_pkg::ST_IDLE,
                cfg_slave_pkg::ST_IGNORE: begin
                    next_state = state;
                end
                default: begin
                    next_state = cfg_slave_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= cfg_slave_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit counter: counts rising edges, wraps at the end of the ack bit
    always_comb begin
        next_bit_cnt = bit_cnt;
        if (start_cond | stop_cond) begin
            next_bit_cnt = cfg_slave_pkg::CNT_ZERO;
        end else if (end_fall) begin
            next_bit_cnt = cfg_slave_pkg::CNT_ZERO;
        end else if (scl_rise & active) begin
            next_bit_cnt = bit_cnt + cfg_slave_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt <= cfg_slave_pkg::CNT_ZERO;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    // shift register: msb first in both directions
    always_comb begin
        next_shift = shift;
        if (receive & sample_bit) begin
            next_shift = {shift[6:0], sda_s};
        end else if (end_fall & start_read) begin
            next_shift = read_byte;
        end else if (in_rd & data_fall) begin
            next_shift = {shift[6:0], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift <= 8'h00;
        end else begin
            shift <= next_shift;
        end
    end

    // direction bit and register address capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rw       <= 1'b0;
            mem_addr <= 8'h00;
        end else begin
            if (ack_fall & in_dev) begin
                rw <= dir_read;
            end
            if (ack_fall & in_mem) begin
                mem_addr <= shift;
            end
        end
    end

    // master acknowledge sampled on the ninth rise of a read byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            master_ack <= 1'b0;
        end else if (ack_rise & in_rd) begin
            master_ack <= ~sda_s;
        end
    end

    // sda drive: ack low on the ninth bit, data bits launched on falls
    always_comb begin
        next_drive = sda_oe;
        if (start_cond | stop_cond) begin
            next_drive = 1'b0;
        end else if (ack_fall) begin
            next_drive = receive & ack_now;
        end else if (end_fall) begin
            next_drive = start_read & ~read_byte[7];
        end else if (in_rd & data_fall) begin
            next_drive = ~shift[6];
        end else if (~active) begin
            next_drive = 1'b0;
        end
    end

    // open drain: the pin is only ever pulled low or released
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe  <= next_drive;
            sda_out <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescaler_cfg <= cfg_slave_pkg::PRESCALER_RST;
        end else if (wr_pre) begin
            prescaler_cfg <= shift;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freq_cfg <= cfg_slave_pkg::FREQ_RST;
        end else if (wr_freq) begin
            freq_cfg <= shift[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_id         <= cfg_slave_pkg::BUS_ID_RST;
            nv_write_defer <= cfg_slave_pkg::DEFER_RST;
        end else if (wr_id) begin
            bus_id         <= shift[cfg_slave_pkg::BUS_ID_LO +: 3];
            nv_write_defer <= shift[cfg_slave_pkg::DEFER_BIT];
        end
    end

    // pending store: set by storing writes and the commit command, cleared when the stop launches it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pending <= 1'b0;
        end else if (nv_needed) begin
            pending <= 1'b1;
        end else if (stop_cond) begin
            pending <= 1'b0;
        end
    end

    // the stop after a storing write starts the nonvolatile write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nv_store <= 1'b0;
        end else begin
            nv_store <= stop_cond & pending;
        end
    end

    // busy window in which the own address is not acknowledged
    nv_write_timer #(
        .CYCLES (NV_WRITE_CYCLES)
    ) u_nv_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (nv_store),
        .busy    (nv_busy)
    );

endmodule

//--- include/cfg_slave_pkg.sv
// constants, states and register layout of the two-wire configuration slave
// assumes a single 25 MHz system clock and an external two-wire bus master
package cfg_slave_pkg;

    // register memory addresses
    localparam logic [7:0] REG_PRESCALER = 8'h02;
    localparam logic [7:0] REG_FREQ      = 8'h08;
    localparam logic [7:0] REG_BUS_ID    = 8'h0D;
    localparam logic [7:0] CMD_NV_COMMIT = 8'h3F;

    // reset values and read fill
    localparam logic [7:0] PRESCALER_RST = 8'hCD;
    localparam logic [3:0] FREQ_RST      = 4'h0;
    localparam logic [2:0] BUS_ID_RST    = 3'h0;
    localparam logic       DEFER_RST     = 1'b0;
    localparam logic [3:0] UPPER_FILL    = 4'hF;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // fixed upper bits of the slave address (default address byte B0h)
    localparam logic [3:0] SLAVE_ADDR_HI = 4'hB;

    // field positions in the bus id register
    localparam int DEFER_BIT = 3;
    localparam int BUS_ID_LO = 0;

    // bit counter values: 8 data rises then the ninth (ack) rise
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;
    localparam logic [3:0] CNT_DATA = 4'h8;
    localparam logic [3:0] CNT_ACK  = 4'h9;

    // timing
    localparam int CLK_FREQ_MHZ = 25;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_MEM_ADDR,
        ST_WR_DATA,
        ST_RD_DATA,
        ST_IGNORE
    } state_t;

endpackage

//--- src/pin_sync.sv
// two-flop synchronisers for the bus pins
// assumes asynchronous pin levels and a single system clock
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] meta;

    // one two-flop chain per pin, reset to the idle high level
    for (genvar i = 0; i < WIDTH; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                meta[i]     <= 1'b1;
                pin_sync[i] <= 1'b1;
            end else begin
                meta[i]     <= pin_in[i];
                pin_sync[i] <= meta[i];
            end
        end
    end

endmodule

//--- src/nv_write_timer.sv
// busy timer covering one nonvolatile write cycle
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
module nv_write_timer #(
    parameter int CYCLES = 250000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control and status
    input  wire logic start,
    output logic      busy
);

    logic [31:0] remain;
    wire         last = (remain == 32'h0000_0001);

    // load on start, count down while busy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remain <= 32'h0000_0000;
        end else if (start) begin
            remain <= 32'(CYCLES);
        end else if (busy) begin
            remain <= remain - 32'h0000_0001;
        end
    end

    // busy flag drops after the last counted cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= 1'b1;
        end else if (last) begin
            busy <= 1'b0;
        end
    end

endmodule

//--- tb/two_wire_config_slave_assertions.sv
// port assertions for the two-wire configuration slave
// assumes scl phases of several clocks and one clock domain
`timescale 1ns/1ps
module two_wire_config_slave_assertions #(
    parameter int NV_WRITE_TIME_US = 10000
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // bus pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // configuration and store status
    input wire logic [7:0] prescaler_cfg,
    input wire logic [3:0] freq_cfg,
    input wire logic [2:0] bus_id,
    input wire logic       nv_write_defer,
    input wire logic       nv_store,
    input wire logic       nv_busy
);
    localparam int BUSY_CYCLES = NV_WRITE_TIME_US * cfg_slave_pkg::CLK_FREQ_MHZ;
    logic [31:0] busy_cnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // cycles spent with the store timer running
    always_ff @(posedge clk) begin
        if (sys_rst || !nv_busy) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= busy_cnt + 32'h1;
        end
    end

    // store pulse followed by the busy window
    sequence s_store;
        nv_store ##1 nv_busy;
    endsequence

    a_rst_values: assert property ($fell(sys_rst) |-> prescaler_cfg == 8'hCD && bus_id == 3'h0
        && freq_cfg == 4'h0 && !nv_write_defer && !sda_oe && !nv_busy && !nv_store)
        else $error("outputs not at reset values");
    a_out_low: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    a_store_busy: assert property (nv_store |-> s_store)
        else $error("store without busy");
    a_store_pulse: assert property (nv_store |=> !nv_store)
        else $error("store pulse too long");
    a_store_stop: assert property (nv_store |-> scl_in && sda_in)
        else $error("store outside a stop");
    a_busy_len: assert property ($fell(nv_busy) |-> busy_cnt == 32'(BUSY_CYCLES))
        else $error("busy window of wrong length");
    a_no_ack_busy: assert property ($rose(sda_oe) |-> !nv_busy)
        else $error("slave drove sda while busy");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda changed while scl high");
endmodule

//--- tb/two_wire_master_model.sv
// bench model of the two-wire bus master
// assumes sda is the resolved wire with a pull-up outside
`timescale 1ns/1ps
module two_wire_master_model (
    // clock
    input wire logic        clk,
    // bus pins
    output logic            scl,
    output logic            sda_pull,
    input wire logic        sda,
    // byte report: byte then ninth bit
    output logic            got_stb,
    output logic [8:0]      got_val
);
    logic       s;
    logic [7:0] d;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        got_stb = 1'b0;
        got_val = 9'h000;
    end

    // wait falling clock edges
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one bit: sda set while scl low, read mid-high
    task automatic bit_cycle(input logic v, output logic r);
        sda_pull = !v;
        w(3);
        scl = 1'b1;
        w(3);
        r = sda;
        w(3);
        scl = 1'b0;
        w(3);
    endtask

    // start or repeated start
    task automatic start();
        sda_pull = 1'b0;
        w(3);
        scl = 1'b1;
        w(6);
        sda_pull = 1'b1;
        w(6);
        scl = 1'b0;
        w(3);
    endtask

    // stop, leaving the bus idle
    task automatic stop();
        sda_pull = 1'b1;
        w(3);
        scl = 1'b1;
        w(6);
        sda_pull = 1'b0;
        w(6);
    endtask

    // one-cycle report of a finished byte
    task automatic report(input logic [8:0] v);
        got_val = v;
        got_stb = 1'b1;
        w(1);
        got_stb = 1'b0;
    endtask

    // byte to the slave, then its ninth bit
    task automatic wbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        report({b, s});
    endtask

    // byte from the slave, then ack or nack
    task automatic rbyte(input logic nack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(nack, s);
        report({d, nack});
    endtask
endmodule

//--- tb/two_wire_config_slave_tb.sv
// self-checking bench for the two-wire configuration slave
// assumes the bench master model and the port checker beside it
`timescale 1ns/1ps
module two_wire_config_slave_tb;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       m_scl;
    logic       m_pull;
    logic       m_stb;
    logic [8:0] m_val;
    logic       sda_out;
    logic       sda_oe;
    logic [7:0] prescaler_cfg;
    logic [3:0] freq_cfg;
    logic [2:0] bus_id;
    logic       nv_write_defer;
    logic       nv_store;
    logic       nv_busy;
    logic [8:0] expq[$];
    logic [7:0] dev;
    logic [7:0] pre;
    logic [2:0] id;
    logic [3:0] fr;
    int         fail_count = 0;
    int         n_checks = 0;
    int         stores = 0;

    // clock and the pulled-up data wire
    always #20 clk = ~clk;
    wire sda = !(m_pull || (sda_oe && !sda_out));

    two_wire_config_slave #(.NV_WRITE_TIME_US(10)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .prescaler_cfg(prescaler_cfg),
        .freq_cfg(freq_cfg), .bus_id(bus_id), .nv_write_defer(nv_write_defer),
        .nv_store(nv_store), .nv_busy(nv_busy));
    two_wire_master_model m (
        .clk(clk), .scl(m_scl), .sda_pull(m_pull), .sda(sda),
        .got_stb(m_stb), .got_val(m_val));

    task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // compare each reported byte with the oldest note; count stores
    always @(posedge clk) begin
        if (nv_store === 1'b1) begin
            stores++;
        end
        if (m_stb === 1'b1) begin
            check("bus_byte", m_val, (expq.size() > 0) ? expq.pop_front() : 9'h1FF);
        end
    end

    // byte transfers with their expected outcome noted
    task automatic wb(input logic [7:0] b, input logic ack);
        expq.push_back({b, !ack});
        m.wbyte(b);
    endtask
    task automatic wreg(input logic [7:0] r, input logic [7:0] v);
        m.start();
        wb(dev, 1'b1);
        wb(r, 1'b1);
        wb(v, 1'b1);
        m.stop();
    endtask
    task automatic rreg(input logic [7:0] r, input logic [7:0] v);
        m.start();
        wb(dev, 1'b1);
        wb(r, 1'b1);
        m.start();
        wb(dev | 8'h01, 1'b1);
        expq.push_back({v, 1'b1});
        m.rbyte(1'b1);
        m.stop();
    endtask

    // bounded wait for the store window to close
    task automatic wait_idle();
        int k;
        k = 0;
        while (nv_busy !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) begin
            fail_count++;
            results();
        end
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h5FFABBA6));
        pre = 8'($urandom);
        id = 3'($urandom);
        fr = 4'($urandom);
        dev = 8'hB0;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check("prescaler", {1'b0, prescaler_cfg}, 9'h0CD);
        check("bus_id", {6'h00, bus_id}, 9'h000);
        check("defer", {8'h00, nv_write_defer}, 9'h000);
        // automatic store, then own address refused while busy
        wreg(8'h02, pre);
        check("prescaler", {1'b0, prescaler_cfg}, {1'b0, pre});
        check("stores", 9'(stores), 9'h001);
        check("busy", {8'h00, nv_busy}, 9'h001);
        m.start();
        wb(dev, 1'b0);
        m.stop();
        wait_idle();
        // foreign address: nothing acked, nothing written
        m.start();
        wb(dev ^ 8'h02, 1'b0);
        wb(8'h08, 1'b0);
        wb(8'h07, 1'b0);
        m.stop();
        check("freq", {5'h00, freq_cfg}, 9'h000);
        rreg(8'h02, pre);
        // bus id register stores at once even in deferred mode
        wreg(8'h0D, {4'h0, 1'b1, id});
        check("bus_id", {6'h00, bus_id}, {6'h00, id});
        check("defer", {8'h00, nv_write_defer}, 9'h001);
        check("stores", 9'(stores), 9'h002);
        wait_idle();
        dev = {4'hB, id, 1'b0};
        wreg(8'h08, {4'h0, fr});
        check("freq", {5'h00, freq_cfg}, {5'h00, fr});
        check("stores", 9'(stores), 9'h002);
        rreg(8'h08, {4'hF, fr});
        // commit command carries no data
        m.start();
        wb(dev, 1'b1);
        wb(8'h3F, 1'b1);
        m.stop();
        check("stores", 9'(stores), 9'h003);
        wait_idle();
        repeat (4) @(negedge clk);
        check("pending", 9'(expq.size()), 9'h000);
        results();
    end

    // watchdog
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule

bind two_wire_config_slave two_wire_config_slave_assertions #(
    .NV_WRITE_TIME_US(NV_WRITE_TIME_US)
) chk (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .prescaler_cfg(prescaler_cfg),
    .freq_cfg(freq_cfg), .bus_id(bus_id), .nv_write_defer(nv_write_defer),
    .nv_store(nv_store), .nv_busy(nv_busy));
